//--- rtl/hpc_pkg.sv
package hpc_pkg;

   // ==========================================================
   // parameter addresses
   localparam logic [15:0] OFS_REF_POL     = 16'h061C;
   localparam logic [15:0] OFS_NEG_LIMIT   = 16'h061E;
   localparam logic [15:0] OFS_POS_LIMIT   = 16'h0620;
   localparam logic [15:0] OFS_SAVED_METH  = 16'h1B38;
   localparam logic [15:0] OFS_SEARCH_SPD  = 16'h2808;
   localparam logic [15:0] OFS_LEAVE_SPD   = 16'h280A;
   localparam logic [15:0] OFS_EDGE_DIST   = 16'h280C;
   localparam logic [15:0] OFS_HOME_POS    = 16'h2816;
   localparam logic [15:0] OFS_OVERRUN     = 16'h281A;

   // ==========================================================
   // reset values
   localparam logic [15:0] RST_REF_POL     = 16'h0001;
   localparam logic [15:0] RST_NEG_LIMIT   = 16'h0001;
   localparam logic [15:0] RST_POS_LIMIT   = 16'h0001;
   localparam logic [15:0] RST_SAVED_METH  = 16'h0012;
   localparam logic [15:0] RST_SEARCH_SPD  = 16'h003C;
   localparam logic [15:0] RST_LEAVE_SPD   = 16'h0006;
   localparam logic [31:0] RST_EDGE_DIST   = 32'h0000_0000;
   localparam logic [31:0] RST_HOME_POS    = 32'h0000_0000;
   localparam logic [31:0] RST_OVERRUN     = 32'h0000_0000;

   // ==========================================================
   // switch evaluation codes
   localparam logic [1:0]  POL_OFF         = 2'h0;
   localparam logic [1:0]  POL_NC          = 2'h1;
   localparam logic [1:0]  POL_NO          = 2'h2;

   // ==========================================================
   // value ranges
   localparam logic [15:0] SPEED_MIN       = 16'h0001;
   localparam logic [15:0] SPEED_MAX       = 16'h0BB8;
   localparam logic [15:0] METHOD_MIN      = 16'h0001;
   localparam logic [15:0] METHOD_MAX      = 16'h0023;
   localparam logic [15:0] NOIDX_MIN       = 16'h0011;
   localparam logic [15:0] NOIDX_MAX       = 16'h001E;
   localparam logic [15:0] METH_NEG_LIMIT  = 16'h0011;
   localparam logic [15:0] METH_POS_LIMIT  = 16'h0012;

   // switch bit positions inside the conditioner vector
   localparam int          SW_REF          = 0;
   localparam int          SW_NEG          = 1;
   localparam int          SW_POS          = 2;

   typedef enum logic [2:0] {
      HPC_IDLE,
      HPC_SEARCH,
      HPC_STOP,
      HPC_RETURN,
      HPC_LEAVE,
      HPC_FAIL
   } hpc_state_t;

endpackage

//--- rtl/hpc_switch_cond.sv
`timescale 1ns/10ps
module hpc_switch_cond
(
   input  wire logic       core_clk,
   input  wire logic       nrst,
   input  wire logic [2:0] pin_raw,
   input  wire logic [5:0] pin_cfg,
   output logic      [2:0] sw_active
);

   logic [2:0] meta;
   logic [2:0] sync;

   genvar i;
   generate
      for (i = 0; i < 3; i = i + 1)
      begin : g_sw
         // two stages before any decision; meta feeds only sync
         always_ff @(posedge core_clk or negedge nrst)
         begin
            if (!nrst)
            begin
               meta[i] <= 1'b0;
               sync[i] <= 1'b0;
            end
            else
            begin
               meta[i] <= pin_raw[i];
               sync[i] <= meta[i];
            end
         end

         // nc reads open circuit as active, which is failsafe
         assign sw_active[i] =
            (pin_cfg[2*i +: 2] == hpc_pkg::POL_NC) ? !sync[i] :
            (pin_cfg[2*i +: 2] == hpc_pkg::POL_NO) ?  sync[i] :
            1'b0; // RQ14
      end
   endgenerate

endmodule

//--- rtl/hpc_dist_monitor.sv
`timescale 1ns/10ps
module hpc_dist_monitor
(
   input  wire logic        core_clk,
   input  wire logic        nrst,
   input  wire logic        run,
   input  wire logic        step_pulse,
   input  wire logic [31:0] limit,
   output logic             exceeded
);

   logic [31:0] travelled;

   // counter saturates so a long run never wraps back below limit
   always_ff @(posedge core_clk or negedge nrst)
   begin
      if (!nrst)
         travelled <= 32'h0000_0000;
      else if (!run)
         travelled <= 32'h0000_0000;
      else if (step_pulse && (travelled != 32'hFFFF_FFFF))
         travelled <= travelled + 32'h0000_0001;
   end

   // zero limit switches the check off
   assign exceeded = (limit != 32'h0000_0000) && (travelled >= limit);

endmodule

//--- rtl/hpc_homing_ctrl.sv
// Function
// [RQ1] reference switch: 1 means normally closed, 2 normally open
// [RQ2] each limit switch: 0 off, 1 normally closed, 2 normally open
// [RQ3] reference switch counts only while homing runs
// [RQ4] switch search uses search speed, 1 to 3000 rpm, default 60
// [RQ5] leaving the switch uses leave speed, 1 to 3000 rpm, default 6
// [RQ6] both speeds clamped to the ramp speed ceiling
// [RQ7] on success load home position value as current position
// [RQ8] edge not found within nonzero edge distance aborts with error
// [RQ9] switch not regained within nonzero overrun distance cancels
// [RQ10] at power-on active method takes the saved default method
// [RQ11] saved default method ranges 1 to 35, default 18
// [RQ12] homing ends on success, halt request or error
// [RQ13] methods 17 to 30: go to switch, then leave its edge
// [RQ14] switch inputs synchronised and turned into active-high flags
`timescale 1ns/10ps
module hpc_homing_ctrl
(
   input  wire logic        core_clk,
   input  wire logic        nrst,
   input  wire logic [15:0] param_addr,
   input  wire logic [31:0] param_wdata,
   input  wire logic        param_wr,
   input  wire logic        param_rd,
   output logic      [31:0] param_rdata,
   output logic             param_rvalid,
   output logic             param_err,
   input  wire logic        method_wr,
   input  wire logic [15:0] method_wdata,
   input  wire logic        homing_start,
   input  wire logic        halt_req,
   input  wire logic        motor_standstill,
   input  wire logic        step_pulse,
   input  wire logic [15:0] ramp_speed_ceiling,
   input  wire logic        reference_switch_input,
   input  wire logic        negative_limit_input,
   input  wire logic        positive_limit_input,
   output logic      [15:0] homing_method_select,
   output logic             homing_active,
   output logic      [15:0] speed_cmd,
   output logic             dir_negative,
   output logic             position_load,
   output logic      [31:0] position_load_value,
   output logic             homing_done,
   output logic             homing_error
);

   // ==========================================================
   // parameter registers
   logic [15:0] ref_switch_polarity_cfg;
   logic [15:0] neg_limit_cfg;
   logic [15:0] pos_limit_cfg;
   logic [15:0] saved_method_default;
   logic [15:0] search_speed;
   logic [15:0] leave_speed;
   logic [31:0] edge_search_max_distance;
   logic [31:0] home_position_value;
   logic [31:0] overrun_search_distance;
   logic        load_pending;

   hpc_pkg::hpc_state_t state;
   hpc_pkg::hpc_state_t next_state;
   logic        search_neg;
   logic        next_search_neg;
   logic [15:0] next_speed;
   logic        next_dir;

   // address decode
   wire hit_ref  = (param_addr == hpc_pkg::OFS_REF_POL);
   wire hit_neg  = (param_addr == hpc_pkg::OFS_NEG_LIMIT);
   wire hit_pos  = (param_addr == hpc_pkg::OFS_POS_LIMIT);
   wire hit_sav  = (param_addr == hpc_pkg::OFS_SAVED_METH);
   wire hit_srch = (param_addr == hpc_pkg::OFS_SEARCH_SPD);
   wire hit_lve  = (param_addr == hpc_pkg::OFS_LEAVE_SPD);
   wire hit_edge = (param_addr == hpc_pkg::OFS_EDGE_DIST);
   wire hit_home = (param_addr == hpc_pkg::OFS_HOME_POS);
   wire hit_ovr  = (param_addr == hpc_pkg::OFS_OVERRUN);
   wire hit_any  = hit_ref | hit_neg | hit_pos | hit_sav | hit_srch |
                   hit_lve | hit_edge | hit_home | hit_ovr;

   // range checks on the written value; out of range is refused
   wire [15:0] wlo      = param_wdata[15:0];
   wire        hi_zero  = (param_wdata[31:16] == 16'h0000);
   wire ok_ref  = hi_zero && (wlo == {14'h0000, hpc_pkg::POL_NC} ||
                              wlo == {14'h0000, hpc_pkg::POL_NO}); // RQ1
   wire ok_lim  = hi_zero && (wlo <= {14'h0000, hpc_pkg::POL_NO}); // RQ2
   wire ok_spd  = hi_zero && (wlo >= hpc_pkg::SPEED_MIN) &&
                  (wlo <= hpc_pkg::SPEED_MAX); // RQ4 RQ5
   wire ok_meth = hi_zero && (wlo >= hpc_pkg::METHOD_MIN) &&
                  (wlo <= hpc_pkg::METHOD_MAX); // RQ11
   wire ok_dist = !param_wdata[31];
   wire ok_val  = (hit_ref & ok_ref) | ((hit_neg | hit_pos) & ok_lim) |
                  (hit_sav & ok_meth) | ((hit_srch | hit_lve) & ok_spd) |
                  ((hit_edge | hit_ovr) & ok_dist) | hit_home;
   wire wr_ok   = param_wr & ok_val;

   // read mux, bits above the register width read as zero
   wire [31:0] rd_mux =
      hit_ref  ? {16'h0000, ref_switch_polarity_cfg} :
      hit_neg  ? {16'h0000, neg_limit_cfg} :
      hit_pos  ? {16'h0000, pos_limit_cfg} :
      hit_sav  ? {16'h0000, saved_method_default} :
      hit_srch ? {16'h0000, search_speed} :
      hit_lve  ? {16'h0000, leave_speed} :
      hit_edge ? edge_search_max_distance :
      hit_home ? home_position_value :
      hit_ovr  ? overrun_search_distance :
      32'h0000_0000;

   // ==========================================================
   // register write port
   always_ff @(posedge core_clk or negedge nrst)
   begin
      if (!nrst)
      begin
         ref_switch_polarity_cfg  <= hpc_pkg::RST_REF_POL;
         neg_limit_cfg            <= hpc_pkg::RST_NEG_LIMIT;
         pos_limit_cfg            <= hpc_pkg::RST_POS_LIMIT;
         saved_method_default     <= hpc_pkg::RST_SAVED_METH; // RQ11
         search_speed             <= hpc_pkg::RST_SEARCH_SPD;
         leave_speed              <= hpc_pkg::RST_LEAVE_SPD;
         edge_search_max_distance <= hpc_pkg::RST_EDGE_DIST;
         home_position_value      <= hpc_pkg::RST_HOME_POS;
         overrun_search_distance  <= hpc_pkg::RST_OVERRUN;
      end
      else if (wr_ok)
      begin
         if (hit_ref)  ref_switch_polarity_cfg  <= wlo;
         if (hit_neg)  neg_limit_cfg            <= wlo;
         if (hit_pos)  pos_limit_cfg            <= wlo;
         if (hit_sav)  saved_method_default     <= wlo;
         if (hit_srch) search_speed             <= wlo;
         if (hit_lve)  leave_speed              <= wlo;
         if (hit_edge) edge_search_max_distance <= param_wdata;
         if (hit_home) home_position_value      <= param_wdata;
         if (hit_ovr)  overrun_search_distance  <= param_wdata;
      end
   end

   // registered read answer and refusal flag
   always_ff @(posedge core_clk or negedge nrst)
   begin
      if (!nrst)
      begin
         param_rdata  <= 32'h0000_0000;
         param_rvalid <= 1'b0;
         param_err    <= 1'b0;
      end
      else
      begin
         param_rvalid <= param_rd;
         param_rdata  <= param_rd ? rd_mux : 32'h0000_0000;
         param_err    <= (param_rd & !hit_any) | (param_wr & !ok_val);
      end
   end

   // ==========================================================
   // active method, reloaded from the saved value after reset
   // constant at reset, saved value copied one edge after release
   always_ff @(posedge core_clk or negedge nrst)
   begin
      if (!nrst)
      begin
         load_pending         <= 1'b1;
         homing_method_select <= hpc_pkg::RST_SAVED_METH;
      end
      else if (load_pending)
      begin
         load_pending         <= 1'b0;
         homing_method_select <= saved_method_default; // RQ10
      end
      else if (method_wr && !homing_active)
         homing_method_select <= method_wdata;
   end

   // ==========================================================
   // switch conditioning and target selection
   logic [2:0] sw_active;

   hpc_switch_cond u_switch
   (
      .core_clk  (core_clk),
      .nrst      (nrst),
      .pin_raw   ({positive_limit_input, negative_limit_input,
                   reference_switch_input}),
      .pin_cfg   ({pos_limit_cfg[1:0], neg_limit_cfg[1:0],
                   ref_switch_polarity_cfg[1:0]}),
      .sw_active (sw_active)
   );

   wire ref_seen   = sw_active[hpc_pkg::SW_REF] & homing_active; // RQ3
   wire neg_seen   = sw_active[hpc_pkg::SW_NEG];
   wire pos_seen   = sw_active[hpc_pkg::SW_POS];
   wire m_neg_lim  = (homing_method_select == hpc_pkg::METH_NEG_LIMIT);
   wire m_pos_lim  = (homing_method_select == hpc_pkg::METH_POS_LIMIT);
   wire m_noidx    = (homing_method_select >= hpc_pkg::NOIDX_MIN) &&
                     (homing_method_select <= hpc_pkg::NOIDX_MAX); // RQ13
   // reference methods: odd codes search negative, even positive
   wire m_neg_dir  = m_neg_lim | (!m_pos_lim & homing_method_select[0]);
   wire target     = m_neg_lim ? neg_seen :
                     m_pos_lim ? pos_seen : ref_seen;
   // a limit that is not the goal, hit in the search direction
   wire stray_lim  = (search_neg & neg_seen & !m_neg_lim) |
                     (!search_neg & pos_seen & !m_pos_lim);

   // speed clamp against the ramp ceiling, whatever was written
   wire [15:0] search_eff = (search_speed > ramp_speed_ceiling) ?
                            ramp_speed_ceiling : search_speed; // RQ6
   wire [15:0] leave_eff  = (leave_speed > ramp_speed_ceiling) ?
                            ramp_speed_ceiling : leave_speed; // RQ6

   // ==========================================================
   // distance monitors
   logic edge_exceeded;
   logic over_exceeded;

   hpc_dist_monitor u_edge_mon
   (
      .core_clk   (core_clk),
      .nrst       (nrst),
      .run        (state == hpc_pkg::HPC_LEAVE),
      .step_pulse (step_pulse),
      .limit      (edge_search_max_distance),
      .exceeded   (edge_exceeded)
   );

   hpc_dist_monitor u_over_mon
   (
      .core_clk   (core_clk),
      .nrst       (nrst),
      .run        (state == hpc_pkg::HPC_RETURN),
      .step_pulse (step_pulse),
      .limit      (overrun_search_distance),
      .exceeded   (over_exceeded)
   );

   // ==========================================================
   // homing sequence; halt wins over every other exit
   always_comb
   begin
      next_state      = state;
      next_search_neg = search_neg;
      case (state)
         hpc_pkg::HPC_IDLE:
            if (homing_start && !load_pending)
            begin
               next_search_neg = m_neg_dir;
               next_state = m_noidx ? hpc_pkg::HPC_SEARCH :
                            hpc_pkg::HPC_FAIL; // RQ13
            end
         hpc_pkg::HPC_SEARCH:
            if (target)
               next_state = hpc_pkg::HPC_STOP;
            else if (stray_lim)
               next_state = hpc_pkg::HPC_FAIL;
         // wait for standstill, then see whether we overran
         hpc_pkg::HPC_STOP:
            if (motor_standstill)
               next_state = target ? hpc_pkg::HPC_LEAVE :
                            hpc_pkg::HPC_RETURN;
         hpc_pkg::HPC_RETURN:
            if (target)
               next_state = hpc_pkg::HPC_LEAVE;
            else if (over_exceeded)
               next_state = hpc_pkg::HPC_FAIL; // RQ9
         hpc_pkg::HPC_LEAVE:
            if (!target)
               next_state = hpc_pkg::HPC_IDLE;
            else if (edge_exceeded)
               next_state = hpc_pkg::HPC_FAIL; // RQ8
         hpc_pkg::HPC_FAIL:
            next_state = hpc_pkg::HPC_IDLE;
         default:
            next_state = hpc_pkg::HPC_IDLE;
      endcase
      if (halt_req && state != hpc_pkg::HPC_IDLE)
         next_state = hpc_pkg::HPC_IDLE; // RQ12
   end

   wire going_active = (next_state == hpc_pkg::HPC_SEARCH) ||
                       (next_state == hpc_pkg::HPC_STOP) ||
                       (next_state == hpc_pkg::HPC_RETURN) ||
                       (next_state == hpc_pkg::HPC_LEAVE);
   wire edge_found   = (state == hpc_pkg::HPC_LEAVE) && !target &&
                       !halt_req;
   wire fail_now     = (next_state == hpc_pkg::HPC_FAIL);

   // speed and direction for the coming state
   assign next_speed = (next_state == hpc_pkg::HPC_SEARCH) ? search_eff :
                       ((next_state == hpc_pkg::HPC_RETURN) ||
                        (next_state == hpc_pkg::HPC_LEAVE)) ? leave_eff :
                       16'h0000; // RQ4 RQ5
   assign next_dir   = (next_state == hpc_pkg::HPC_SEARCH) ?
                       next_search_neg : !next_search_neg;

   always_ff @(posedge core_clk or negedge nrst)
   begin
      if (!nrst)
      begin
         state      <= hpc_pkg::HPC_IDLE;
         search_neg <= 1'b0;
      end
      else
      begin
         state      <= next_state;
         search_neg <= next_search_neg;
      end
   end

   // registered drive outputs and completion pulses
   always_ff @(posedge core_clk or negedge nrst)
   begin
      if (!nrst)
      begin
         homing_active       <= 1'b0;
         speed_cmd           <= 16'h0000;
         dir_negative        <= 1'b0;
         position_load       <= 1'b0;
         position_load_value <= 32'h0000_0000;
         homing_done         <= 1'b0;
         homing_error        <= 1'b0;
      end
      else
      begin
         homing_active <= going_active; // RQ12
         speed_cmd     <= next_speed;
         dir_negative  <= next_dir;
         position_load <= edge_found;
         homing_done   <= edge_found;
         homing_error  <= fail_now;
         if (edge_found)
            position_load_value <= home_position_value; // RQ7
      end
   end

   // ==========================================================
   // checks
   chk_ref_ignored: assert property (@(posedge core_clk) disable iff (!nrst)
      !homing_active |-> !ref_seen) // RQ3
      else $error("reference switch seen outside homing");
   chk_limit_off: assert property (@(posedge core_clk) disable iff (!nrst)
      (neg_limit_cfg[1:0] == hpc_pkg::POL_OFF) |-> !neg_seen) // RQ2
      else $error("disabled negative limit reported active");
   chk_speed_clamp: assert property (@(posedge core_clk) disable iff (!nrst)
      speed_cmd <= $past(ramp_speed_ceiling)) // RQ6
      else $error("speed command above ramp ceiling");
   chk_search_rate: assert property (@(posedge core_clk) disable iff (!nrst)
      (state == hpc_pkg::HPC_SEARCH) |-> speed_cmd == $past(search_eff)) // RQ4
      else $error("search speed not applied");
   chk_leave_rate: assert property (@(posedge core_clk) disable iff (!nrst)
      (state == hpc_pkg::HPC_LEAVE) |-> speed_cmd == $past(leave_eff)) // RQ5
      else $error("leave speed not applied");
   chk_home_load: assert property (@(posedge core_clk) disable iff (!nrst)
      position_load |-> homing_done &&
      position_load_value == $past(home_position_value)) // RQ7
      else $error("home position not loaded");
   chk_edge_abort: assert property (@(posedge core_clk) disable iff (!nrst)
      (state == hpc_pkg::HPC_LEAVE) && edge_exceeded && target && !halt_req
      |=> homing_error && !homing_active ##1 !homing_error) // RQ8
      else $error("edge search overrun not aborted");
   chk_overrun_stop: assert property (@(posedge core_clk) disable iff (!nrst)
      (state == hpc_pkg::HPC_RETURN) && over_exceeded && !target &&
      !halt_req |=> homing_error) // RQ9
      else $error("overrun search not cancelled");
   chk_boot_method: assert property (@(posedge core_clk) disable iff (!nrst)
      $fell(load_pending) |->
      homing_method_select == $past(saved_method_default)) // RQ10
      else $error("saved method not restored");
   chk_halt_ends: assert property (@(posedge core_clk) disable iff (!nrst)
      homing_active && halt_req |=> !homing_active [*2]) // RQ12
      else $error("halt did not end homing");
   chk_bad_method: assert property (@(posedge core_clk) disable iff (!nrst)
      (state == hpc_pkg::HPC_IDLE) && homing_start && !load_pending &&
      !m_noidx |=> homing_error && !homing_active) // RQ13
      else $error("unsupported method accepted");

endmodule

//--- tb/hpc_motor_model.sv
`timescale 1ns/10ps
module hpc_motor_model
(
   input  wire logic        core_clk,
   input  wire logic        nrst,
   input  wire logic [15:0] speed_cmd,
   input  wire logic        dir_negative,
   input  wire logic        ref_no,
   input  wire logic        lim_no,
   input  wire logic        stuck,
   input  wire logic [3:0]  coast,
   output logic             step_pulse,
   output logic             motor_standstill,
   output logic             reference_switch_input,
   output logic             negative_limit_input,
   output logic             positive_limit_input
);
   // ==========================================================
   // motion
   int         pos;
   logic [1:0] div;
   logic [3:0] left;
   logic       dir;
   wire        moving = speed_cmd != 16'h0000 || left != 4'h0;
   wire        stp    = moving && div == 2'h3;
   wire        d_neg  = speed_cmd != 16'h0000 ? dir_negative : dir;

   // one step per four cycles; coast models a slow stop after speed 0
   always_ff @(posedge core_clk or negedge nrst)
   begin
      if (!nrst)
      begin
         pos <= 0;
         div <= 2'h0;
         left <= 4'h0;
         dir <= 1'b0;
         step_pulse <= 1'b0;
      end
      else
      begin
         div <= div + 2'h1;
         step_pulse <= stp;
         dir <= d_neg;
         if (speed_cmd != 16'h0000)
            left <= coast;
         else if (stp)
            left <= left - 4'h1;
         if (stp)
            pos <= d_neg ? pos - 1 : pos + 1;
      end
   end

   assign motor_standstill = !moving;

   // ==========================================================
   // switches: normally open pins go high when hit
   wire ref_on = stuck || (pos >= -24 && pos <= -22);
   assign reference_switch_input = ref_on ~^ ref_no;
   assign negative_limit_input   = (pos <= -40) ~^ lim_no;
   assign positive_limit_input   = (pos >= 20) ~^ lim_no;
endmodule

//--- tb/tb_top.sv
`timescale 1ns/10ps
module tb_top;
   logic        core_clk = 1'b0;
   logic        nrst = 1'b0;
   logic [15:0] param_addr = 16'h0000;
   logic [31:0] param_wdata = 32'h0000_0000;
   logic        param_wr = 1'b0;
   logic        param_rd = 1'b0;
   logic        method_wr = 1'b0;
   logic [15:0] method_wdata = 16'h0000;
   logic        homing_start = 1'b0;
   logic        halt_req = 1'b0;
   logic [15:0] ramp_speed_ceiling = 16'h0032;
   logic        ref_no = 1'b0;
   logic        lim_no = 1'b0;
   logic        stuck = 1'b0;
   logic [3:0]  coast = 4'h0;
   logic [31:0] param_rdata, position_load_value;
   logic [15:0] homing_method_select, speed_cmd, lspd;
   logic        param_rvalid, param_err, motor_standstill, step_pulse;
   logic        reference_switch_input, negative_limit_input;
   logic        positive_limit_input, homing_active, dir_negative;
   logic        position_load, homing_done, homing_error;
   int          failures = 0;
   int          checked = 0;
   int          cyc;

   always #10 core_clk = ~core_clk;

   hpc_homing_ctrl dut
   (
      .core_clk, .nrst, .param_addr, .param_wdata, .param_wr, .param_rd,
      .param_rdata, .param_rvalid, .param_err, .method_wr, .method_wdata,
      .homing_start, .halt_req, .motor_standstill, .step_pulse,
      .ramp_speed_ceiling, .reference_switch_input, .negative_limit_input,
      .positive_limit_input, .homing_method_select, .homing_active,
      .speed_cmd, .dir_negative, .position_load, .position_load_value,
      .homing_done, .homing_error
   );

   hpc_motor_model far_side
   (
      .core_clk, .nrst, .speed_cmd, .dir_negative, .ref_no, .lim_no,
      .stuck, .coast, .step_pulse, .motor_standstill,
      .reference_switch_input, .negative_limit_input, .positive_limit_input
   );

   // ==========================================================
   // helpers
   task automatic chk(input logic ok, input string m);
      checked++;
      if (ok !== 1'b1)
      begin
         failures++;
         $display("CHECK FAILED %0t %s", $time, m);
      end
   endtask

   task automatic tick(input int n);
      repeat (n) @(posedge core_clk);
      #1;
   endtask

   // leading tick keeps strobes from being lowered and raised at once
   task automatic acc(input logic w, input logic [15:0] a,
                      input logic [31:0] d, input logic e);
      tick(1);
      param_addr = a;
      param_wdata = d;
      param_wr = w;
      param_rd = !w;
      tick(1);
      param_wr = 1'b0;
      param_rd = 1'b0;
      chk(param_err === e, "error flag");
      if (!w)
         chk(param_rdata === d && (e || param_rvalid === 1'b1), "read");
   endtask

   task automatic start(input logic [15:0] m);
      tick(1);
      method_wdata = m;
      method_wr = 1'b1;
      tick(1);
      method_wr = 1'b0;
      homing_start = 1'b1;
      tick(1);
      homing_start = 1'b0;
   endtask

   // leaves in the cycle where the done or error pulse stands
   task automatic wait_end;
      lspd = 16'h0000;
      for (cyc = 0; homing_active === 1'b1; cyc++)
      begin
         if (dir_negative === 1'b1 && speed_cmd !== 16'h0000)
            lspd = speed_cmd;
         if (cyc > 3000)
         begin
            failures++;
            end_of_test();
         end
         tick(1);
      end
   endtask

   task automatic end_of_test;
      if (failures == 0 && checked > 0)
         $display("SIMULATION PASSED");
      else
         $display("SIMULATION FAILED");
      $finish;
   endtask

   // ==========================================================
   // scenarios
   task automatic regs_check;
      logic [15:0] a [9] = '{16'h061C, 16'h061E, 16'h0620, 16'h1B38,
         16'h2808, 16'h280A, 16'h280C, 16'h2816, 16'h281A};
      logic [31:0] e [9] = '{32'h1, 32'h1, 32'h1, 32'h12, 32'h3C, 32'h6,
         32'h0, 32'h0, 32'h0};
      logic [15:0] ba [8] = '{16'h061C, 16'h061C, 16'h061E, 16'h1B38,
         16'h1B38, 16'h2808, 16'h280A, 16'h280C};
      logic [31:0] bd [8] = '{32'h0, 32'h3, 32'h3, 32'h0, 32'h24, 32'h0,
         32'hBB9, 32'h8000_0000};
      chk(homing_method_select === 16'h0012, "power-on method");
      for (int i = 0; i < 9; i++)
         acc(1'b0, a[i], e[i], 1'b0);
      for (int i = 0; i < 8; i++)
         acc(1'b1, ba[i], bd[i], 1'b1);
      acc(1'b0, 16'h2808, 32'h3C, 1'b0);
      acc(1'b1, 16'h1B38, 32'h23, 1'b0);
      acc(1'b0, 16'h1B38, 32'h23, 1'b0);
      acc(1'b0, 16'h1234, 32'h0, 1'b1);
   endtask

   task automatic home_ok;
      acc(1'b1, 16'h061E, 32'h2, 1'b0);
      acc(1'b1, 16'h0620, 32'h2, 1'b0);
      acc(1'b1, 16'h2808, 32'h64, 1'b0);
      acc(1'b1, 16'h2816, 32'h1234, 1'b0);
      lim_no = 1'b1;
      start(16'h0012);
      chk(homing_active === 1'b1 && dir_negative === 1'b0, "go");
      chk(speed_cmd === 16'h0032, "clamped search speed");
      wait_end();
      chk(homing_done === 1'b1 && homing_error === 1'b0, "done");
      chk(position_load === 1'b1 && position_load_value === 32'h1234,
          "home value");
      chk(lspd === 16'h0006, "leave speed");
   endtask

   task automatic halt_mid;
      acc(1'b1, 16'h061E, 32'h0, 1'b0);
      ramp_speed_ceiling = 16'h0BB8;
      start(16'h0011);
      chk(speed_cmd === 16'h0064 && dir_negative === 1'b1, "search");
      tick(5);
      halt_req = 1'b1;
      tick(1);
      chk(homing_done === 1'b0 && homing_error === 1'b0, "halt");
      tick(1);
      chk(homing_active === 1'b0 && homing_done === 1'b0, "halted");
      halt_req = 1'b0;
   endtask

   // switch never released: edge distance must abort
   task automatic edge_err;
      acc(1'b1, 16'h061C, 32'h2, 1'b0);
      acc(1'b1, 16'h280C, 32'h5, 1'b0);
      ref_no = 1'b1;
      stuck = 1'b1;
      start(16'h0013);
      wait_end();
      chk(homing_error === 1'b1 && cyc > 16 && cyc < 60, "edge");
      stuck = 1'b0;
      acc(1'b1, 16'h280C, 32'h0, 1'b0);
   endtask

   // slow stop overruns the switch; return gets one step
   task automatic overrun_err;
      acc(1'b1, 16'h281A, 32'h1, 1'b0);
      coast = 4'h8;
      start(16'h0013);
      wait_end();
      chk(homing_error === 1'b1 && homing_done === 1'b0, "overrun");
      coast = 4'h0;
      for (int i = 0; i < 2; i++)
      begin
         start(i ? 16'h001F : 16'h0010);
         chk(homing_error === 1'b1 && homing_active === 1'b0, "code");
      end
   endtask

   initial
   begin
      repeat (16) @(posedge core_clk);
      #1 nrst = 1'b1;
      regs_check();
      home_ok();
      halt_mid();
      edge_err();
      overrun_err();
      end_of_test();
   end
endmodule
